// file: common/bms_pkg.sv
// Shared constants, types and helpers for the bit instruction execution unit.
// Assumes 14-bit instruction words and an 8-bit file register data path.
package bms_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int INSN_W      = 14;
  localparam int FILE_ADDR_W = 7;
  localparam int BIT_SEL_W   = 3;
  localparam int DATA_W      = 8;
  localparam int FILE_DEPTH  = 128;

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int OPC_MSB  = 13;
  localparam int OPC_LSB  = 12;
  localparam int SEL_MSB  = 11;
  localparam int SEL_LSB  = 10;
  localparam int BIT_MSB  = 9;
  localparam int BIT_LSB  = 7;
  localparam int ADDR_MSB = 6;
  localparam int ADDR_LSB = 0;

  localparam logic [1:0]  OPC_BIT_GROUP = 2'h1;
  localparam logic [1:0]  SEL_CLEAR     = 2'h0;
  localparam logic [1:0]  SEL_SET       = 2'h1;
  localparam logic [1:0]  SEL_TEST_ZERO = 2'h2;
  localparam logic [13:0] NOP_WORD      = 14'h0000;

  // ----------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [13:0] RST_INSN   = 14'h0000;
  localparam logic [7:0]  RST_DATA   = 8'h00;
  localparam int          PLAIN_CYCLES = 1;
  localparam int          SKIP_CYCLES  = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    other_op                 = 3'h0,
    clear_register_bit_op    = 3'h1,
    set_register_bit_op      = 3'h2,
    test_bit_skip_if_zero_op = 3'h3,
    no_operation_op          = 3'h4
  } bms_op_t;

  typedef enum logic [1:0] {
    bms_st_run  = 2'b01,
    bms_st_kill = 2'b10
  } bms_state_t;

  // Selects one bit of a data byte.
  function automatic logic [7:0] bms_bit_mask(input logic [2:0] pos);
    bms_bit_mask = 8'h01 << pos;
  endfunction : bms_bit_mask

endpackage : bms_pkg

// file: dv/bms_prog_mem.sv
// Program memory model that feeds queued instruction words to the execution unit.
// Assumes the bench pushes words and may set slow to leave a gap after each word.
`timescale 1ns/1ps
module bms_prog_mem (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  output logic      [13:0] fetch_word,
  output logic             fetch_valid
);
  logic [13:0] word_q[$];
  logic        slow;
  logic        idle;

  initial begin
    fetch_word  = 14'h0000;
    fetch_valid = 1'b0;
    slow        = 1'b0;
    idle        = 1'b0;
  end

  task automatic push(input logic [13:0] w);
    word_q.push_back(w);
  endtask : push

  // Between words the bus inverts each cycle, so every second idle cycle shows the last word again.
  always @(posedge ref_clk) begin
    #2;
    if (!sys_rst && word_q.size() > 0 && !idle) begin
      fetch_word  = word_q.pop_front();
      fetch_valid = 1'b1;
      idle        = slow;
    end else begin
      fetch_word  = ~fetch_word;
      fetch_valid = 1'b0;
      idle        = 1'b0;
    end
  end
endmodule : bms_prog_mem

// file: dv/testbench.sv
// Self-checking bench for the bit instruction execution unit.
// Assumes the program memory model in bms_prog_mem and a 200 MHz clock.
`timescale 1ns/1ps
module testbench;
  logic ref_clk, sys_rst, load_en, fetch_valid, exec_valid, exec_skip;
  logic [13:0] fetch_word;
  logic [6:0]  load_addr, peek_addr, exec_addr;
  logic [7:0]  load_data, exec_data, peek_data;
  logic [7:0]  mem [128];
  logic [2:0]  exec_bit;
  logic [37:0] rq[$];
  bms_pkg::bms_op_t exec_op;
  int err_count, cmp_count, cyc, last;

  bms_exec i_bms_exec (.ref_clk(ref_clk), .sys_rst(sys_rst), .fetch_word(fetch_word), .fetch_valid(fetch_valid),
    .load_en(load_en), .load_addr(load_addr), .load_data(load_data), .peek_addr(peek_addr), .exec_op(exec_op),
    .exec_valid(exec_valid), .exec_addr(exec_addr), .exec_bit(exec_bit), .exec_skip(exec_skip),
    .exec_data(exec_data), .peek_data(peek_data));
  bms_prog_mem i_bms_prog_mem (.ref_clk(ref_clk), .sys_rst(sys_rst), .fetch_word(fetch_word),
    .fetch_valid(fetch_valid));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Collects every executed instruction with its cycle number.
  always @(negedge ref_clk) begin
    cyc++;
    if (exec_valid === 1'b1) rq.push_back({16'(cyc), 3'(exec_op), exec_skip, exec_bit, exec_addr, exec_data});
  end

  function automatic logic [13:0] ins(input logic [1:0] sel, input logic [2:0] b, input logic [6:0] a);
    return {bms_pkg::OPC_BIT_GROUP, sel, b, a};
  endfunction : ins

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic load(input logic [6:0] a, input logic [7:0] d);
    load_en   = 1'b1;
    load_addr = a;
    load_data = d;
    mem[a]    = d;
    step(1);
    load_en   = 1'b0;
    step(1);
  endtask : load

  task automatic peek(input logic [6:0] a);
    peek_addr = a;
    step(2);
    chk(peek_data, mem[a]);
  endtask : peek

  // Takes the next executed instruction and compares its fields and spacing.
  task automatic expect_rec(input logic [2:0] op, input logic [2:0] b, input logic [6:0] a, input logic sk,
                            input logic [7:0] d, input int gap);
    logic [37:0] r;
    for (int i = 0; i < 50 && rq.size() == 0; i++) step(1);
    if (rq.size() == 0) begin
      err_count++;
      $display("BAD t=%0t no instruction executed", $time);
      conclude();
    end
    r = rq.pop_front();
    chk(r[21:19], op);
    chk(r[17:8], {b, a});
    chk(r[18], sk);
    if (op != 3'h4 && op != 3'h0) chk(r[7:0], d);
    if (gap > 0) chk(r[37:22] - last, gap);
    last = r[37:22];
  endtask : expect_rec

  task automatic t_set_clear;
    load(7'h7F, 8'hC7);
    load(7'h00, 8'h0A);
    i_bms_prog_mem.push(ins(2'h0, 3'h7, 7'h7F));
    i_bms_prog_mem.push(ins(2'h1, 3'h7, 7'h00));
    for (int b = 0; b < 8; b++) i_bms_prog_mem.push(ins(2'h1, 3'(b), 7'h40));
    mem[7'h7F] = 8'h47;
    mem[7'h00] = 8'h8A;
    expect_rec(3'h1, 3'h7, 7'h7F, 1'b0, 8'h47, 0);
    expect_rec(3'h2, 3'h7, 7'h00, 1'b0, 8'h8A, 1);
    for (int b = 0; b < 8; b++) begin
      mem[7'h40] = mem[7'h40] | (8'h01 << b);
      expect_rec(3'h2, 3'(b), 7'h40, 1'b0, mem[7'h40], 1);
    end
    peek(7'h7F);
    peek(7'h00);
    peek(7'h40);
    $display("test set_clear done");
  endtask : t_set_clear

  task automatic t_skip;
    load(7'h55, 8'h02);
    i_bms_prog_mem.push(ins(2'h2, 3'h1, 7'h55));
    i_bms_prog_mem.push(ins(2'h1, 3'h4, 7'h55));
    i_bms_prog_mem.push(ins(2'h2, 3'h0, 7'h55));
    i_bms_prog_mem.push(ins(2'h1, 3'h7, 7'h55));
    i_bms_prog_mem.push(ins(2'h0, 3'h1, 7'h55));
    expect_rec(3'h3, 3'h1, 7'h55, 1'b0, 8'h02, 0);
    expect_rec(3'h2, 3'h4, 7'h55, 1'b0, 8'h12, 1);
    expect_rec(3'h3, 3'h0, 7'h55, 1'b1, 8'h12, 1);
    expect_rec(3'h4, 3'h0, 7'h00, 1'b0, 8'h00, 1);
    expect_rec(3'h1, 3'h1, 7'h55, 1'b0, 8'h10, 1);
    mem[7'h55] = 8'h10;
    peek(7'h55);
    $display("test skip done");
  endtask : t_skip

  task automatic t_slow;
    i_bms_prog_mem.slow = 1'b1;
    i_bms_prog_mem.push(ins(2'h2, 3'h7, 7'h7F));
    i_bms_prog_mem.push(ins(2'h1, 3'h0, 7'h7F));
    i_bms_prog_mem.push(ins(2'h1, 3'h3, 7'h7F));
    expect_rec(3'h3, 3'h7, 7'h7F, 1'b1, 8'h47, 0);
    expect_rec(3'h4, 3'h0, 7'h00, 1'b0, 8'h00, 2);
    expect_rec(3'h2, 3'h3, 7'h7F, 1'b0, 8'h4F, 2);
    mem[7'h7F] = 8'h4F;
    peek(7'h7F);
    i_bms_prog_mem.slow = 1'b0;
    $display("test slow done");
  endtask : t_slow

  task automatic t_other;
    i_bms_prog_mem.push(ins(2'h3, 3'h5, 7'h2A));
    i_bms_prog_mem.push(14'h0000);
    expect_rec(3'h0, 3'h5, 7'h2A, 1'b0, 8'h00, 0);
    expect_rec(3'h4, 3'h0, 7'h00, 1'b0, 8'h00, 1);
    peek(7'h2A);
    $display("test other done");
  endtask : t_other

  initial begin
    sys_rst   = 1'b1;
    load_en   = 1'b0;
    load_addr = 7'h00;
    load_data = 8'h00;
    peek_addr = 7'h33;
    foreach (mem[i]) mem[i] = 8'h00;
    step(20);
    sys_rst = 1'b0;
    chk(exec_valid, 1'b0);
    peek(7'h33);
    t_set_clear();
    t_skip();
    t_slow();
    t_other();
    step(4);
    chk(rq.size(), 0);
    conclude();
  end
endmodule : testbench

// file: verilog/bms_bit_decode.sv
// Combinational decoder for the bit instruction group.
// Assumes the instruction word is held stable by the caller for the cycle.
`timescale 1ns/1ps
module bms_bit_decode (
  input  wire logic [13:0]   insn,
  output bms_pkg::bms_op_t   op,
  output logic [6:0]         addr,
  output logic [2:0]         bitpos
);

  // ----------------------------------------------------------------
  // Field split and opcode selection.
  // ----------------------------------------------------------------
  always_comb begin
    addr   = insn[bms_pkg::ADDR_MSB:bms_pkg::ADDR_LSB];
    bitpos = insn[bms_pkg::BIT_MSB:bms_pkg::BIT_LSB];
    op     = bms_pkg::other_op;
    if (insn == bms_pkg::NOP_WORD) begin
      op = bms_pkg::no_operation_op;
    end else if (insn[bms_pkg::OPC_MSB:bms_pkg::OPC_LSB] == bms_pkg::OPC_BIT_GROUP) begin
      unique case (insn[bms_pkg::SEL_MSB:bms_pkg::SEL_LSB])
        bms_pkg::SEL_CLEAR:     op = bms_pkg::clear_register_bit_op;
        bms_pkg::SEL_SET:       op = bms_pkg::set_register_bit_op;
        bms_pkg::SEL_TEST_ZERO: op = bms_pkg::test_bit_skip_if_zero_op;
        default:                op = bms_pkg::other_op;
      endcase
    end
  end

endmodule : bms_bit_decode

// file: verilog/bms_exec.sv
// Execution unit for bit clear, bit set and bit test with skip.
// Assumes program memory presents fetch_word with fetch_valid on ref_clk.
//
// Notes on behaviour
// - File address 0..127, bit position 0..7.
// - Test skips next when addressed bit zero.
// - Next word fetched while current one executes.
// - Skip discards prefetched word, runs no-operation.
`timescale 1ns/1ps
module bms_exec #(
  parameter int FILE_DEPTH = bms_pkg::FILE_DEPTH
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [13:0] fetch_word,
  input  wire logic        fetch_valid,
  input  wire logic        load_en,
  input  wire logic [6:0]  load_addr,
  input  wire logic [7:0]  load_data,
  input  wire logic [6:0]  peek_addr,
  output bms_pkg::bms_op_t exec_op,
  output logic             exec_valid,
  output logic [6:0]       exec_addr,
  output logic [2:0]       exec_bit,
  output logic             exec_skip,
  output logic [7:0]       exec_data,
  output logic [7:0]       peek_data
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [13:0]          ir_reg;
  logic [13:0]          ir_next;
  logic                 ir_valid_reg;
  logic                 ir_valid_next;
  bms_pkg::bms_state_t  state_reg;
  bms_pkg::bms_state_t  state_next;
  logic [7:0]           file_mem [FILE_DEPTH];
  bms_pkg::bms_op_t     dec_op;
  logic [6:0]           dec_addr;
  logic [2:0]           dec_bit;
  logic [7:0]           cur_data;
  logic                 tested_bit;
  logic                 skip_now;
  logic                 wr_en;
  logic [7:0]           wr_data;
  bms_pkg::bms_op_t     exec_op_reg;
  bms_pkg::bms_op_t     exec_op_next;
  logic                 exec_valid_reg;
  logic                 exec_valid_next;
  logic [6:0]           exec_addr_reg;
  logic [6:0]           exec_addr_next;
  logic [2:0]           exec_bit_reg;
  logic [2:0]           exec_bit_next;
  logic                 exec_skip_reg;
  logic                 exec_skip_next;
  logic [7:0]           exec_data_reg;
  logic [7:0]           exec_data_next;
  logic [7:0]           peek_data_reg;
  logic [7:0]           peek_data_next;

  // ----------------------------------------------------------------
  // Decode of the held instruction.
  // ----------------------------------------------------------------
  bms_bit_decode u_decode (
    .insn   (ir_reg),
    .op     (dec_op),
    .addr   (dec_addr),
    .bitpos (dec_bit)
  );

  // ----------------------------------------------------------------
  // Execution and prefetch pipeline.
  // ----------------------------------------------------------------
  always_comb begin
    cur_data   = file_mem[dec_addr];
    tested_bit = cur_data[dec_bit];
    skip_now   = ir_valid_reg && (dec_op == bms_pkg::test_bit_skip_if_zero_op) && !tested_bit;
    wr_en      = ir_valid_reg && ((dec_op == bms_pkg::clear_register_bit_op) ||
                                  (dec_op == bms_pkg::set_register_bit_op));
    if (dec_op == bms_pkg::clear_register_bit_op) begin
      wr_data = cur_data & ~bms_pkg::bms_bit_mask(dec_bit);
    end else begin
      wr_data = cur_data | bms_pkg::bms_bit_mask(dec_bit);
    end
    ir_next       = ir_reg;
    ir_valid_next = 1'b0;
    state_next    = state_reg;
    if (fetch_valid) begin
      ir_valid_next = 1'b1;
      state_next    = bms_pkg::bms_st_run;
      if (skip_now || (state_reg == bms_pkg::bms_st_kill)) begin
        ir_next = bms_pkg::NOP_WORD;
      end else begin
        ir_next = fetch_word;
      end
    end else if (skip_now) begin
      state_next = bms_pkg::bms_st_kill;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ir_reg       <= bms_pkg::RST_INSN;
      ir_valid_reg <= 1'b0;
      state_reg    <= bms_pkg::bms_st_run;
    end else begin
      ir_reg       <= ir_next;
      ir_valid_reg <= ir_valid_next;
      state_reg    <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // File register store. Execution wins over a load in the same cycle.
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_mem[i] <= bms_pkg::RST_DATA;
      end
    end else if (wr_en) begin
      file_mem[dec_addr] <= wr_data;
    end else if (load_en) begin
      file_mem[load_addr] <= load_data;
    end
  end

  // ----------------------------------------------------------------
  // Reported results.
  // ----------------------------------------------------------------
  always_comb begin
    exec_valid_next = ir_valid_reg;
    exec_op_next    = ir_valid_reg ? dec_op : bms_pkg::other_op;
    exec_addr_next  = dec_addr;
    exec_bit_next   = dec_bit;
    exec_skip_next  = skip_now;
    exec_data_next  = wr_en ? wr_data : cur_data;
    peek_data_next  = file_mem[peek_addr];
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      exec_valid_reg <= 1'b0;
      exec_op_reg    <= bms_pkg::other_op;
      exec_addr_reg  <= '0;
      exec_bit_reg   <= '0;
      exec_skip_reg  <= 1'b0;
      exec_data_reg  <= bms_pkg::RST_DATA;
      peek_data_reg  <= bms_pkg::RST_DATA;
    end else begin
      exec_valid_reg <= exec_valid_next;
      exec_op_reg    <= exec_op_next;
      exec_addr_reg  <= exec_addr_next;
      exec_bit_reg   <= exec_bit_next;
      exec_skip_reg  <= exec_skip_next;
      exec_data_reg  <= exec_data_next;
      peek_data_reg  <= peek_data_next;
    end
  end

  assign exec_valid = exec_valid_reg;
  assign exec_op    = exec_op_reg;
  assign exec_addr  = exec_addr_reg;
  assign exec_bit   = exec_bit_reg;
  assign exec_skip  = exec_skip_reg;
  assign exec_data  = exec_data_reg;
  assign peek_data  = peek_data_reg;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_skip_decided;
    skip_now && fetch_valid;
  endsequence

  sequence s_nop_slot;
    exec_skip ##1 (exec_valid && (exec_op == bms_pkg::no_operation_op));
  endsequence

  a_skip_runs_nop: assert property (s_skip_decided |=> s_nop_slot)
    else $error("Skip did not replace the next instruction with a no-operation.");

  a_test_no_skip: assert property (
    ir_valid_reg && (dec_op == bms_pkg::test_bit_skip_if_zero_op) && tested_bit && fetch_valid
    |=> !exec_skip && (ir_reg == $past(fetch_word)))
    else $error("Test with bit set disturbed the next instruction.");

  a_prefetch_held: assert property (
    fetch_valid && !skip_now && (state_reg == bms_pkg::bms_st_run)
    |=> ir_valid_reg && (ir_reg == $past(fetch_word)))
    else $error("Prefetched word was not held for execution.");

  a_kill_pending: assert property (
    (skip_now || (state_reg == bms_pkg::bms_st_kill)) && !fetch_valid
    |=> state_reg == bms_pkg::bms_st_kill)
    else $error("Skip without a waiting word did not hold the discard pending.");

  a_kill_late_word: assert property (
    (state_reg == bms_pkg::bms_st_kill) && fetch_valid
    |=> ir_valid_reg && (ir_reg == bms_pkg::NOP_WORD))
    else $error("Late word after a skip was not discarded.");

  a_clear_bit: assert property (
    ir_valid_reg && (dec_op == bms_pkg::clear_register_bit_op)
    |=> !file_mem[$past(dec_addr)][$past(dec_bit)] && exec_valid)
    else $error("Clear left the addressed bit set.");

  a_set_bit: assert property (
    ir_valid_reg && (dec_op == bms_pkg::set_register_bit_op)
    |=> file_mem[$past(dec_addr)][$past(dec_bit)] && !exec_skip)
    else $error("Set left the addressed bit clear.");

  a_operand_fields: assert property (
    ir_valid_reg |=> (exec_addr == $past(ir_reg[6:0])) && (exec_bit == $past(ir_reg[9:7])))
    else $error("Reported operands differ from the instruction fields.");

endmodule : bms_exec
